// [bench/charger_profile_pin_status_regs_bench.sv]
// Self-checking bench for the profile, pin status and configuration register block.
`timescale 1ns/10ps
module charger_profile_pin_status_regs_bench;
  localparam logic [14:0] APPLIED = 15'h2000;
  localparam logic [14:0] NOHS = 15'h1000;
  localparam logic [14:0] CUSTOM_ACCEPT_BIT = 15'h0800;
  localparam logic [14:0] DCP = 15'h0400;
  localparam logic [14:0] CDP = 15'h0200;
  localparam logic [14:0] LEG0 = 15'h0004;
  localparam logic [14:0] REM = 15'h0001;
  logic clk, rst_n, reg_wr, reg_rd, reg_rvalid_q, wake_request_q, source_uvlo_raw;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, rd;
  logic custom_limit_trip, polarity_high_q, port_switch_on_q, hs_switch_closed_q, trip_limit_q;
  cpps_pkg::cpps_pins_t pins_raw;
  cpps_pkg::cpps_power_state_field_t power_state;
  cpps_pkg::cpps_emu_evt_t emu_evt;
  cpps_pkg::cpps_cfg_t cfg_q;
  cpps_pkg::cpps_ctl_t ctl_q;
  int bad_count, check_count, cycles;
  logic [7:0] tbl_a [9] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h25, 8'h30};
  logic [7:0] tbl_e [9] = '{8'h00, 8'h00, 8'h05, 8'h01, 8'h8c, 8'h04, 8'h45, 8'h14, 8'h00};

  cpps_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

  cpps_regs DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .wake_request_q(wake_request_q), .pins_raw(pins_raw),
    .source_uvlo_raw(source_uvlo_raw), .power_state(power_state), .emu_evt(emu_evt),
    .custom_limit_trip(custom_limit_trip), .cfg_q(cfg_q), .ctl_q(ctl_q),
    .polarity_high_q(polarity_high_q), .port_switch_on_q(port_switch_on_q),
    .hs_switch_closed_q(hs_switch_closed_q), .trip_limit_q(trip_limit_q));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      $display("Error at %0t: run did not finish", $time);
      results();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s gave %h, expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s is %b, expected %b", $time, what, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host.rd_reg(a, rd);
    chk8(rd, exp, "register read");
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Pulses are raised for exactly one edge so the design sees single events.
  task automatic pulse(input logic [14:0] m);
    @(posedge clk);
    #1;
    emu_evt = cpps_pkg::cpps_emu_evt_t'(emu_evt | m);
    @(posedge clk);
    #1;
    emu_evt = cpps_pkg::cpps_emu_evt_t'(emu_evt & ~m);
  endtask

  initial begin
    rst_n = 1'b0;
    pins_raw = '0;
    pins_raw.polarity_select = 1'b1;
    source_uvlo_raw = 1'b0;
    power_state = cpps_pkg::CPPS_PWR_SLEEP;
    emu_evt = '0;
    custom_limit_trip = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    idle(12);
    for (int i = 0; i < 9; i++) rdc(tbl_a[i], tbl_e[i]);
    chk1(trip_limit_q, 1'b1, "trip after reset");
    for (int i = 0; i < 3; i++) host.wr_reg(tbl_a[i], 8'hff);
    host.wr_reg(8'h30, 8'hff);
    for (int i = 0; i < 3; i++) rdc(tbl_a[i], tbl_e[i]);
    rdc(8'h30, 8'h00);
    host.wr_reg(8'h15, 8'h5a);
    rdc(8'h15, 8'h5a);
    $display("registers test done");
    for (int i = 0; i < 4; i++) begin
      power_state = cpps_pkg::cpps_power_state_field_t'(i);
      rdc(8'h14, 8'h04 | ((i == 0) ? 8'h01 : 8'(i)));
    end
    power_state = cpps_pkg::CPPS_PWR_ACTIVE;
    $display("power state test done");
    pins_raw.mode_select_one = 1'b1;
    pins_raw.emulation_enable = 1'b1;
    idle(8);
    rdc(8'h14, 8'h1e);
    host.wr_reg(8'h17, 8'h94);
    idle(3);
    rdc(8'h14, 8'h26);
    pins_raw = 5'b10000;
    host.wr_reg(8'h17, 8'h06);
    idle(8);
    rdc(8'h14, 8'h46);
    chk1(port_switch_on_q, 1'b1, "port switch");
    source_uvlo_raw = 1'b1;
    idle(8);
    rdc(8'h12, 8'h10);
    chk1(port_switch_on_q, 1'b0, "port switch in lockout");
    source_uvlo_raw = 1'b0;
    idle(8);
    rdc(8'h12, 8'h00);
    $display("pin mirror test done");
    pulse(DCP);
    rdc(8'h12, 8'h04);
    chk1(hs_switch_closed_q, 1'b0, "data switch for DCP");
    chk1(trip_limit_q, 1'b0, "limit for DCP");
    host.wr_reg(8'h25, 8'h15);
    idle(3);
    chk1(hs_switch_closed_q, 1'b1, "data switch for DCP");
    pulse(REM);
    rdc(8'h12, 8'h00);
    host.wr_reg(8'h25, 8'h14);
    pulse(CDP);
    rdc(8'h12, 8'h02);
    chk1(hs_switch_closed_q, 1'b1, "data switch for CDP");
    chk1(trip_limit_q, 1'b1, "limit for CDP");
    host.wr_reg(8'h17, 8'h0e);
    idle(3);
    rdc(8'h12, 8'h00);
    host.wr_reg(8'h17, 8'h06);
    custom_limit_trip = 1'b0;
    host.wr_reg(8'h25, 8'h1c);
    pulse(CUSTOM_ACCEPT_BIT);
    rdc(8'h12, 8'h08);
    chk1(hs_switch_closed_q, 1'b1, "data switch for custom");
    chk1(trip_limit_q, 1'b0, "limit for custom");
    host.wr_reg(8'h17, 8'h04);
    idle(3);
    rdc(8'h12, 8'h00);
    host.wr_reg(8'h17, 8'h06);
    host.wr_reg(8'h25, 8'h14);
    custom_limit_trip = 1'b1;
    idle(3);
    $display("profile accept test done");
    for (int i = 0; i < 7; i++) begin
      pulse(LEG0 << i);
      rdc(8'h13, 8'h01 << i);
      chk1(hs_switch_closed_q, 1'b0, "data switch for legacy");
      chk1(trip_limit_q, 1'b1, "limit for legacy");
      pulse(REM);
      rdc(8'h13, 8'h00);
    end
    $display("legacy test done");
    pulse(NOHS);
    rdc(8'h12, 8'h00);
    @(posedge clk);
    #1;
    emu_evt.dedicated_emulation_cycle = 1'b1;
    pulse(NOHS);
    rdc(8'h12, 8'h80);
    pulse(APPLIED);
    rdc(8'h12, 8'h00);
    pulse(DCP);
    pulse(NOHS);
    rdc(8'h12, 8'h04);
    pulse(REM);
    emu_evt.dedicated_emulation_cycle = 1'b0;
    $display("no handshake test done");
    @(posedge clk);
    #1;
    emu_evt.passthrough_active = 1'b1;
    idle(2);
    rdc(8'h12, 8'h01);
    chk1(hs_switch_closed_q, 1'b1, "data switch for pass-through");
    chk1(trip_limit_q, 1'b1, "limit for pass-through");
    pulse(REM);
    idle(2);
    rdc(8'h12, 8'h00);
    host.wr_reg(8'h17, 8'h0e);
    idle(3);
    rdc(8'h12, 8'h01);
    $display("pass-through test done");
    results();
  end
endmodule

// [bench/cpps_host_model.sv]
// Host model that issues register reads and writes on the strobe port.
`timescale 1ns/10ps
module cpps_host_model (
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic clk,
  input wire logic [7:0] reg_rdata_q
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Released lines are inverted so a design that samples outside a strobe sees wrong values.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata_q;
  endtask
endmodule

// [bench/cpps_regs_props.sv]
// Concurrent checks on the ports of the profile, pin status and configuration register block.
`timescale 1ns/10ps
module cpps_regs_props #(
  parameter int STRAP_SETTLE = cpps_pkg::STRAP_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic reg_rvalid_q,
  input wire logic wake_request_q,
  input wire logic source_uvlo_raw,
  input wire cpps_pkg::cpps_cfg_t cfg_q,
  input wire cpps_pkg::cpps_ctl_t ctl_q,
  input wire logic polarity_high_q,
  input wire logic port_switch_on_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_access;
    reg_rd || reg_wr;
  endsequence
  sequence s_read(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_write(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence

  property p_read_answer;
    reg_rd |=> reg_rvalid_q;
  endproperty
  property p_no_stray_answer;
    !reg_rd |=> !reg_rvalid_q;
  endproperty
  property p_wake;
    s_access |=> wake_request_q;
  endproperty
  property p_never_sleep;
    s_read(cpps_pkg::ADDR_PIN_STATUS) |=> reg_rdata_q[1:0] != 2'b00;
  endproperty
  property p_pin_top;
    s_read(cpps_pkg::ADDR_PIN_STATUS) |=> !reg_rdata_q[7];
  endproperty
  property p_profile_gap;
    s_read(cpps_pkg::ADDR_PROFILE_A) |=> reg_rdata_q[6:5] == 2'b00;
  endproperty
  property p_legacy_top;
    s_read(cpps_pkg::ADDR_LEGACY) |=> !reg_rdata_q[7];
  endproperty
  property p_cfg_write;
    s_write(cpps_pkg::ADDR_GENERAL) |=> cfg_q.general == $past(reg_wdata);
  endproperty
  property p_cfg_reset;
    $rose(rst_n) |-> cfg_q == {cpps_pkg::RST_GENERAL, cpps_pkg::RST_EMULATION,
      cpps_pkg::RST_SWITCH, cpps_pkg::RST_ATTACH, cpps_pkg::RST_DATA_SWITCH};
  endproperty
  property p_uvlo_off;
    source_uvlo_raw [*8] |-> !port_switch_on_q;
  endproperty
  property p_disabled_off;
    !ctl_q.port_power_enable [*2] |-> !port_switch_on_q;
  endproperty
  property p_strap_hold;
    !$fell(polarity_high_q);
  endproperty

  a_read_answer: assert property (p_read_answer) else $error("read without answer");
  a_no_stray_answer: assert property (p_no_stray_answer) else $error("stray read answer");
  a_wake: assert property (p_wake) else $error("access did not wake");
  a_never_sleep: assert property (p_never_sleep) else $error("sleep code read");
  a_pin_top: assert property (p_pin_top) else $error("pin status bit 7 set");
  a_profile_gap: assert property (p_profile_gap) else $error("profile bits 6:5 set");
  a_legacy_top: assert property (p_legacy_top) else $error("legacy bit 7 set");
  a_cfg_write: assert property (p_cfg_write) else $error("general write lost");
  a_cfg_reset: assert property (p_cfg_reset) else $error("bad config reset");
  a_uvlo_off: assert property (p_uvlo_off) else $error("switch on in lockout");
  a_disabled_off: assert property (p_disabled_off) else $error("switch on while off");
  a_strap_hold: assert property (p_strap_hold) else $error("polarity changed");
endmodule

bind cpps_regs cpps_regs_props #(.STRAP_SETTLE(STRAP_SETTLE)) u_props (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
  .wake_request_q(wake_request_q), .source_uvlo_raw(source_uvlo_raw), .cfg_q(cfg_q),
  .ctl_q(ctl_q), .polarity_high_q(polarity_high_q), .port_switch_on_q(port_switch_on_q)
);

// [design/cpps_pin_sync.sv]
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/10ps
module cpps_pin_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_raw,
  output logic [WIDTH-1:0] pin_stable_q
);

  initial begin
    if (WIDTH < 1) begin
      $error("cpps_pin_sync: WIDTH must be at least 1");
    end
  end

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync2_q;
  logic [WIDTH-1:0] sync3_q;

  // The first stage feeds only the second stage, never the agreement check.
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
          pin_stable_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= meta_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi]) begin
            pin_stable_q[gi] <= sync3_q[gi];
          end
        end
      end
    end
  endgenerate

endmodule

// [design/cpps_pkg.sv]
// Constants and types shared by the profile, pin status and configuration register block.
// Function
// - Profile status bits never drive alert or attach
// - Clear custom/DCP/CDP/pass-through on disable, mode, removal
// - Seven legacy bits, same clear conditions
// - No-handshake only in dedicated cycle; cleared per profile
// - No-handshake set at profile end, exclusive
// - Undervoltage flag holds port switch off
// - Custom accept: custom switch and limit settings
// - DCP accept: dedicated switch bit, constant limiting
// - CDP accept: switch closed, trip limiting
// - Pass-through: bit set, switch closed, trip
// - Pass-through bit re-reports only after mode-one toggle
// - Legacy accept: dedicated switch bit, custom limit
// - Mirror effective controls into pin status bits
// - Polarity strap decoded once after reset
// - Two-bit power state field reported live
// - Bus access wakes; sleep code never read
// - Configuration reset values as listed
// - Controls are pin OR set bit unless ignored
package cpps_pkg;

  localparam logic [7:0] ADDR_PROFILE_A = 8'h12;
  localparam logic [7:0] ADDR_LEGACY = 8'h13;
  localparam logic [7:0] ADDR_PIN_STATUS = 8'h14;
  localparam logic [7:0] ADDR_GENERAL = 8'h15;
  localparam logic [7:0] ADDR_EMULATION = 8'h16;
  localparam logic [7:0] ADDR_SWITCH = 8'h17;
  localparam logic [7:0] ADDR_ATTACH = 8'h18;
  localparam logic [7:0] ADDR_DATA_SWITCH = 8'h25;

  localparam logic [7:0] RST_GENERAL = 8'h01;
  localparam logic [7:0] RST_EMULATION = 8'h8c;
  localparam logic [7:0] RST_SWITCH = 8'h04;
  localparam logic [7:0] RST_ATTACH = 8'h45;
  localparam logic [7:0] RST_DATA_SWITCH = 8'h14;

  // Profile status A fields.
  localparam int PA_NO_HANDSHAKE = 7;
  localparam int PA_UNDERVOLT = 4;
  localparam int PA_CUSTOM = 3;
  localparam int PA_DCP = 2;
  localparam int PA_CDP = 1;
  localparam int PA_PASSTHROUGH = 0;

  // Switch configuration fields.
  localparam int SW_PIN_IGNORE = 7;
  localparam int SW_EMULATION_ENABLE_SET = 5;
  localparam int SW_M2_SET = 4;
  localparam int SW_M1_SET = 3;
  localparam int SW_PORT_POWER_ENABLE_SET = 1;

  // Data switch configuration fields.
  localparam int DS_HSW_CUSTOM_ACCEPT_BIT = 3;
  localparam int DS_DEDICATED_CYCLE_SWITCH_CTL = 0;

  // Pin status fields.
  localparam int PS_PORT_POWER_ENABLE = 6;
  localparam int PS_M2 = 5;
  localparam int PS_M1 = 4;
  localparam int PS_EMULATION_ENABLE = 3;
  localparam int PS_POLARITY = 2;

  localparam int NUM_LEGACY = 7;
  localparam int STRAP_SETTLE_CYCLES = 4;

  typedef enum logic [1:0] {
    CPPS_PWR_SLEEP = 2'b00,
    CPPS_PWR_DETECT = 2'b01,
    CPPS_PWR_ACTIVE = 2'b10,
    CPPS_PWR_ERROR = 2'b11
  } cpps_power_state_field_t;

  // External control pins, raw or synchronised.
  typedef struct packed {
    logic polarity_select;
    logic port_power_enable;
    logic mode_select_two;
    logic mode_select_one;
    logic emulation_enable;
  } cpps_pins_t;

  // Events and levels from the emulation engine, same clock.
  typedef struct packed {
    logic dedicated_emulation_cycle;
    logic profile_applied;
    logic profile_end_no_handshake_flag;
    logic custom_accept;
    logic dcp_accept;
    logic cdp_accept;
    logic [NUM_LEGACY-1:0] legacy_accept;
    logic passthrough_active;
    logic removal;
  } cpps_emu_evt_t;

  typedef struct packed {
    logic [7:0] general;
    logic [7:0] emulation;
    logic [7:0] switch_cfg;
    logic [7:0] attach;
    logic [7:0] data_switch;
  } cpps_cfg_t;

  // Effective controls after the pin and set bit combination.
  typedef struct packed {
    logic port_power_enable;
    logic mode_select_two;
    logic mode_select_one;
    logic emulation_enable;
  } cpps_ctl_t;

endpackage

// [design/cpps_profile_status.sv]
// Accepted-profile indicators with their clear conditions and pass-through re-arm.
`timescale 1ns/10ps
module cpps_profile_status (
  input wire logic clk,
  input wire logic rst_n,
  input wire cpps_pkg::cpps_emu_evt_t evt,
  input wire logic clear_evt,
  input wire logic mode_one_toggle,
  output logic no_handshake_flag_q,
  output logic custom_accept_bit_q,
  output logic dcp_bit_q,
  output logic cdp_bit_q,
  output logic passthrough_bit_q,
  output logic [cpps_pkg::NUM_LEGACY-1:0] legacy_accept_q
);

  logic pt_armed_q;
  logic any_accept;

  assign any_accept = evt.custom_accept | evt.dcp_accept | evt.cdp_accept
                      | (|evt.legacy_accept);

  // A setting event in the same cycle as a clear wins, so no acceptance is lost.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      custom_accept_bit_q <= 1'b0;
      dcp_bit_q <= 1'b0;
      cdp_bit_q <= 1'b0;
    end else begin
      custom_accept_bit_q <= evt.custom_accept | (custom_accept_bit_q & ~clear_evt);
      dcp_bit_q <= evt.dcp_accept | (dcp_bit_q & ~clear_evt);
      cdp_bit_q <= evt.cdp_accept | (cdp_bit_q & ~clear_evt);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < cpps_pkg::NUM_LEGACY; gi++) begin : g_legacy
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          legacy_accept_q[gi] <= 1'b0;
        end else begin
          legacy_accept_q[gi] <= evt.legacy_accept[gi] | (legacy_accept_q[gi] & ~clear_evt);
        end
      end
    end
  endgenerate

  // Pass-through reports once per arming; removal clears it but does not re-arm.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pt_armed_q <= 1'b1;
      passthrough_bit_q <= 1'b0;
    end else begin
      if (evt.passthrough_active && pt_armed_q) begin
        passthrough_bit_q <= 1'b1;
        pt_armed_q <= 1'b0;
      end else begin
        passthrough_bit_q <= passthrough_bit_q & ~clear_evt;
        if (mode_one_toggle) begin
          pt_armed_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      no_handshake_flag_q <= 1'b0;
    end else if (any_accept || evt.profile_applied || evt.passthrough_active
                 || !evt.dedicated_emulation_cycle) begin
      no_handshake_flag_q <= 1'b0;
    end else if (evt.profile_end_no_handshake_flag && !custom_accept_bit_q && !dcp_bit_q
                 && !cdp_bit_q && !passthrough_bit_q && !(|legacy_accept_q)) begin
      no_handshake_flag_q <= 1'b1;
    end
  end

endmodule

// [design/cpps_regs.sv]
// Top of the profile, pin status and configuration register block.
`timescale 1ns/10ps
module cpps_regs #(
  parameter int STRAP_SETTLE = cpps_pkg::STRAP_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  output logic wake_request_q,
  input wire cpps_pkg::cpps_pins_t pins_raw,
  input wire logic source_uvlo_raw,
  input wire cpps_pkg::cpps_power_state_field_t power_state,
  input wire cpps_pkg::cpps_emu_evt_t emu_evt,
  input wire logic custom_limit_trip,
  output cpps_pkg::cpps_cfg_t cfg_q,
  output cpps_pkg::cpps_ctl_t ctl_q,
  output logic polarity_high_q,
  output logic port_switch_on_q,
  output logic hs_switch_closed_q,
  output logic trip_limit_q
);

  initial begin
    if (STRAP_SETTLE < 3 || STRAP_SETTLE > 255) begin
      $error("cpps_regs: STRAP_SETTLE must lie in 3..255");
    end
  end

  localparam logic [7:0] SETTLE_LAST = 8'(STRAP_SETTLE);

  cpps_pkg::cpps_pins_t pins_sync;
  logic [1:0] uvlo_sync;
  logic source_undervoltage_flag;

  cpps_pin_sync #(
    .WIDTH(5)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_raw(pins_raw),
    .pin_stable_q(pins_sync)
  );

  cpps_pin_sync #(
    .WIDTH(2)
  ) u_uvlo_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_raw({1'b0, source_uvlo_raw}),
    .pin_stable_q(uvlo_sync)
  );

  assign source_undervoltage_flag = uvlo_sync[0];

  // Polarity strap: caught once, after the synchroniser has settled past reset.
  logic [7:0] settle_cnt_q;
  logic strap_done_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt_q <= 8'h00;
      strap_done_q <= 1'b0;
      polarity_high_q <= 1'b0;
    end else if (!strap_done_q) begin
      if (settle_cnt_q == SETTLE_LAST) begin
        strap_done_q <= 1'b1;
        polarity_high_q <= pins_sync.polarity_select;
      end else begin
        settle_cnt_q <= settle_cnt_q + 8'h01;
      end
    end
  end

  // Configuration registers; the status addresses accept no write.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q.general <= cpps_pkg::RST_GENERAL;
      cfg_q.emulation <= cpps_pkg::RST_EMULATION;
      cfg_q.switch_cfg <= cpps_pkg::RST_SWITCH;
      cfg_q.attach <= cpps_pkg::RST_ATTACH;
      cfg_q.data_switch <= cpps_pkg::RST_DATA_SWITCH;
    end else if (reg_wr) begin
      unique case (reg_addr)
        cpps_pkg::ADDR_GENERAL: begin
          cfg_q.general <= reg_wdata;
        end
        cpps_pkg::ADDR_EMULATION: begin
          cfg_q.emulation <= reg_wdata;
        end
        cpps_pkg::ADDR_SWITCH: begin
          cfg_q.switch_cfg <= reg_wdata;
        end
        cpps_pkg::ADDR_ATTACH: begin
          cfg_q.attach <= reg_wdata;
        end
        cpps_pkg::ADDR_DATA_SWITCH: begin
          cfg_q.data_switch <= reg_wdata;
        end
        default: begin
          cfg_q.general <= cfg_q.general;
        end
      endcase
    end
  end

  // Effective controls: pin OR set bit, or set bit alone when pins are ignored.
  logic pin_ignore;
  logic pwr_pin_active;
  cpps_pkg::cpps_ctl_t ctl_d;

  assign pin_ignore = cfg_q.switch_cfg[cpps_pkg::SW_PIN_IGNORE];
  assign pwr_pin_active = polarity_high_q ? pins_sync.port_power_enable
                                          : ~pins_sync.port_power_enable;

  always_comb begin
    ctl_d.port_power_enable = cfg_q.switch_cfg[cpps_pkg::SW_PORT_POWER_ENABLE_SET]
                              | (~pin_ignore & strap_done_q & pwr_pin_active);
    ctl_d.mode_select_two = cfg_q.switch_cfg[cpps_pkg::SW_M2_SET]
                            | (~pin_ignore & pins_sync.mode_select_two);
    ctl_d.mode_select_one = cfg_q.switch_cfg[cpps_pkg::SW_M1_SET]
                            | (~pin_ignore & pins_sync.mode_select_one);
    ctl_d.emulation_enable = cfg_q.switch_cfg[cpps_pkg::SW_EMULATION_ENABLE_SET]
                             | (~pin_ignore & pins_sync.emulation_enable);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= '0;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // Clear causes for the accepted-profile bits.
  logic power_disable_evt;
  logic mode_change_evt;
  logic mode_one_toggle;
  logic clear_evt;

  assign power_disable_evt = ctl_q.port_power_enable & ~ctl_d.port_power_enable;
  assign mode_one_toggle = ctl_q.mode_select_one ^ ctl_d.mode_select_one;
  assign mode_change_evt = mode_one_toggle
                           | (ctl_q.mode_select_two ^ ctl_d.mode_select_two)
                           | (ctl_q.emulation_enable ^ ctl_d.emulation_enable);
  assign clear_evt = power_disable_evt | mode_change_evt | emu_evt.removal;

  logic no_handshake_flag;
  logic custom_accept_bit;
  logic dcp_bit;
  logic cdp_bit;
  logic passthrough_bit;
  logic [cpps_pkg::NUM_LEGACY-1:0] legacy_accept;

  cpps_profile_status u_profile (
    .clk(clk),
    .rst_n(rst_n),
    .evt(emu_evt),
    .clear_evt(clear_evt),
    .mode_one_toggle(mode_one_toggle),
    .no_handshake_flag_q(no_handshake_flag),
    .custom_accept_bit_q(custom_accept_bit),
    .dcp_bit_q(dcp_bit),
    .cdp_bit_q(cdp_bit),
    .passthrough_bit_q(passthrough_bit),
    .legacy_accept_q(legacy_accept)
  );

  // Data switch and current limit follow whichever profile was accepted.
  // These indicators feed no alert or attach output, so they stay side-effect free.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_switch_closed_q <= 1'b0;
      trip_limit_q <= 1'b1;
    end else if (custom_accept_bit) begin
      hs_switch_closed_q <= cfg_q.data_switch[cpps_pkg::DS_HSW_CUSTOM_ACCEPT_BIT];
      trip_limit_q <= custom_limit_trip;
    end else if (dcp_bit) begin
      hs_switch_closed_q <= cfg_q.data_switch[cpps_pkg::DS_DEDICATED_CYCLE_SWITCH_CTL];
      trip_limit_q <= 1'b0;
    end else if (cdp_bit || passthrough_bit) begin
      hs_switch_closed_q <= 1'b1;
      trip_limit_q <= 1'b1;
    end else if (|legacy_accept) begin
      hs_switch_closed_q <= cfg_q.data_switch[cpps_pkg::DS_DEDICATED_CYCLE_SWITCH_CTL];
      trip_limit_q <= custom_limit_trip;
    end else begin
      hs_switch_closed_q <= 1'b0;
      trip_limit_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_switch_on_q <= 1'b0;
    end else begin
      port_switch_on_q <= ctl_d.port_power_enable & ~source_undervoltage_flag;
    end
  end

  // Status words assembled for reading.
  logic [7:0] profile_a_word;
  logic [7:0] legacy_word;
  logic [7:0] pin_word;
  logic [1:0] state_code;

  // Any access wakes the device, so a sleep code is shown as detect.
  assign state_code = (power_state == cpps_pkg::CPPS_PWR_SLEEP)
                      ? cpps_pkg::CPPS_PWR_DETECT : power_state;

  always_comb begin
    profile_a_word = 8'h00;
    profile_a_word[cpps_pkg::PA_NO_HANDSHAKE] = no_handshake_flag;
    profile_a_word[cpps_pkg::PA_UNDERVOLT] = source_undervoltage_flag;
    profile_a_word[cpps_pkg::PA_CUSTOM] = custom_accept_bit;
    profile_a_word[cpps_pkg::PA_DCP] = dcp_bit;
    profile_a_word[cpps_pkg::PA_CDP] = cdp_bit;
    profile_a_word[cpps_pkg::PA_PASSTHROUGH] = passthrough_bit;
    legacy_word = {1'b0, legacy_accept};
    pin_word = 8'h00;
    pin_word[cpps_pkg::PS_PORT_POWER_ENABLE] = ctl_q.port_power_enable;
    pin_word[cpps_pkg::PS_M2] = ctl_q.mode_select_two;
    pin_word[cpps_pkg::PS_M1] = ctl_q.mode_select_one;
    pin_word[cpps_pkg::PS_EMULATION_ENABLE] = ctl_q.emulation_enable;
    pin_word[cpps_pkg::PS_POLARITY] = polarity_high_q;
    pin_word[1:0] = state_code;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        unique case (reg_addr)
          cpps_pkg::ADDR_PROFILE_A: begin
            reg_rdata_q <= profile_a_word;
          end
          cpps_pkg::ADDR_LEGACY: begin
            reg_rdata_q <= legacy_word;
          end
          cpps_pkg::ADDR_PIN_STATUS: begin
            reg_rdata_q <= pin_word;
          end
          cpps_pkg::ADDR_GENERAL: begin
            reg_rdata_q <= cfg_q.general;
          end
          cpps_pkg::ADDR_EMULATION: begin
            reg_rdata_q <= cfg_q.emulation;
          end
          cpps_pkg::ADDR_SWITCH: begin
            reg_rdata_q <= cfg_q.switch_cfg;
          end
          cpps_pkg::ADDR_ATTACH: begin
            reg_rdata_q <= cfg_q.attach;
          end
          cpps_pkg::ADDR_DATA_SWITCH: begin
            reg_rdata_q <= cfg_q.data_switch;
          end
          default: begin
            reg_rdata_q <= 8'h00;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_request_q <= 1'b0;
    end else begin
      wake_request_q <= reg_rd | reg_wr;
    end
  end

endmodule
